// [label_parser_pkg.sv]
package label_parser_pkg;

	// byte codes seen by the parser
	localparam logic [7:0] CODE_BS = 8'h08;
	localparam logic [7:0] CODE_LF = 8'h0A;
	localparam logic [7:0] CODE_FF = 8'h0C;
	localparam logic [7:0] CODE_CR = 8'h0D;
	localparam logic [7:0] CODE_ESC = 8'h1B;
	localparam logic [7:0] CODE_SPACE = 8'h20;
	localparam logic [7:0] CH_AMP = 8'h26;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_G = 8'h47;
	localparam logic [7:0] CH_K = 8'h4B;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_Y = 8'h59;
	localparam logic [7:0] CH_Z = 8'h5A;
	localparam logic [7:0] CH_D_LOW = 8'h64;
	localparam logic [7:0] CH_V_LOW = 8'h76;

	// line geometry and colour limits
	localparam logic [6:0] COL_FIRST = 7'h00;
	localparam logic [6:0] COL_LAST = 7'h4F;
	localparam logic [4:0] COLOUR_MAX = 5'h0F;
	localparam logic [4:0] COLOUR_SAT = 5'h10;
	localparam logic [7:0] COLOUR_SAT_W = 8'h10;
	localparam logic [7:0] DEC_BASE = 8'h0A;
	localparam logic [1:0] COLOUR_SEQ_MAX = 2'h3;
	localparam logic [3:0] COLOUR_NONE = 4'h0;

	// register map, byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int CTRL_ITEM_LSB = 0;
	localparam int CTRL_COLOUR_BIT = 8;
	localparam int ST_COL_LSB = 0;
	localparam int ST_LIT_BIT = 8;
	localparam int ST_BLINK_BIT = 9;
	localparam int ST_INV_BIT = 10;
	localparam int ST_UL_BIT = 11;
	localparam int ST_FG_LSB = 12;
	localparam int ST_BG_LSB = 16;
	localparam int ST_CNT_LSB = 20;
	localparam int ST_ERR_BIT = 24;
	localparam logic [7:0] RST_ITEM = 8'h00;
	localparam logic RST_COLOUR_SUPPORT = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// parser states
	typedef enum logic [2:0] {
		P_TEXT = 3'b000,
		P_ESC = 3'b001,
		P_ESC_LIT = 3'b010,
		P_AMP = 3'b011,
		P_ENH = 3'b100,
		P_CSIGN = 3'b101,
		P_CNUM = 3'b110
	} pstate_e;

endpackage

// [label_text_escape_parser.sv]
`timescale 1ns/1ps
// Overview of operation
// - backspace moves pen left one column
// - form feed blanks line, pen to left
// - carriage return puts pen at left
// - escape byte opens every multi-byte command
// - escape C moves pen right one
// - escape G acts as carriage return
// - escape K clears to end of line
// - escape Y sets literal mode; escape Z is drawn in it, so never clears it
// - enhancement is escape, ampersand, d, selector
// - selector picks blink, inverse, underline combinations
// - enhancements only with nonzero item number
// - escape ampersand v number S overrides colour
// - colour 1 to 15 sets foreground
// - colour -15 to -1 sets background
// - colour zero restores pen-select colour
// - at most three colour sequences per label
// - colour sequences need nonzero item number
// - colourless variant flags colour sequence error
// - literal mode draws control and escape bytes
// - literal mode still executes CR and LF
// - normal mode executes, never draws, controls
// - new label clears literal mode
// - nonzero item forces literal, ignores Y/Z
module label_text_escape_parser
	import label_parser_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic labelStart,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	output logic glyphValid,
	output logic [7:0] glyphCode,
	output logic [6:0] penCol,
	output logic clearLine,
	output logic clearToEnd,
	output logic lineFeed,
	output logic literalMode,
	output logic blink,
	output logic inverse,
	output logic underline,
	output logic [3:0] fgColour,
	output logic [3:0] bgColour,
	output logic colourError
);

	////////////////////////////////////////////////////////////////////////
	// state record
	typedef struct packed {
		logic awReady; // address channel open
		logic wReady; // data channel open
		logic awHeld; // write address captured
		logic wHeld; // write data captured
		logic [3:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [7:0] itemNumber; // nonzero enables attributes
		logic colourSupport; // variant has colour pens
		pstate_e pst; // parser position in a sequence
		logic [6:0] penCol;
		logic literal;
		logic blink;
		logic inverse;
		logic underline;
		logic [3:0] fg; // zero means pen-select colour
		logic [3:0] bg;
		logic [1:0] colourCount; // sequences honoured this label
		logic negative;
		logic hasDigit;
		logic [4:0] number; // saturates above the colour range
		logic error; // sticky colour-on-mono error
		logic glyphValid;
		logic [7:0] glyphCode;
		logic clearLine;
		logic clearToEnd;
		logic lineFeed;
	} state_s;

	state_s s;
	state_s next_s;

	////////////////////////////////////////////////////////////////////////
	// next-state logic: bus slave and parser in one process
	always_comb
	begin
		logic [31:0] statusWord;
		logic [7:0] acc;
		logic itemSet;
		logic asText;
		logic doWrite;
		statusWord = '0;
		acc = '0;
		itemSet = 1'b0;
		asText = 1'b0;
		doWrite = 1'b0;
		next_s = s;
		// one-cycle pulses fall by default
		next_s.glyphValid = 1'b0;
		next_s.clearLine = 1'b0;
		next_s.clearToEnd = 1'b0;
		next_s.lineFeed = 1'b0;
		itemSet = (s.itemNumber != RST_ITEM);

		// status word assembled from live parser state
		statusWord[ST_COL_LSB +: 7] = s.penCol;
		statusWord[ST_LIT_BIT] = s.literal;
		statusWord[ST_BLINK_BIT] = s.blink;
		statusWord[ST_INV_BIT] = s.inverse;
		statusWord[ST_UL_BIT] = s.underline;
		statusWord[ST_FG_LSB +: 4] = s.fg;
		statusWord[ST_BG_LSB +: 4] = s.bg;
		statusWord[ST_CNT_LSB +: 2] = s.colourCount;
		statusWord[ST_ERR_BIT] = s.error;

		// write channels taken in either order
		if (awvalid && s.awReady)
		begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = awaddr;
		end
		if (wvalid && s.wReady)
		begin
			next_s.wHeld = 1'b1;
			next_s.wData = wdata;
			next_s.wStrb = wstrb;
		end
		if (s.bValid && bready)
		begin
			next_s.bValid = 1'b0;
		end
		// both halves present: commit and answer
		if (s.awHeld && s.wHeld && !s.bValid)
		begin
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.bValid = 1'b1;
			next_s.bResp = RESP_OKAY;
			doWrite = 1'b1;
			if (s.awAddr == ADDR_CTRL)
			begin
				if (s.wStrb[0])
				begin
					next_s.itemNumber = s.wData[CTRL_ITEM_LSB +: 8];
				end
				if (s.wStrb[1])
				begin
					next_s.colourSupport = s.wData[CTRL_COLOUR_BIT];
				end
			end
			else if (s.awAddr != ADDR_STATUS)
			begin
				// unmapped address
				next_s.bResp = RESP_SLVERR;
			end
		end
		next_s.awReady = !next_s.awHeld && !next_s.bValid;
		next_s.wReady = !next_s.wHeld && !next_s.bValid;

		// read channel: one outstanding, answer next cycle
		if (s.rValid && rready)
		begin
			next_s.rValid = 1'b0;
		end
		if (arvalid && s.arReady)
		begin
			next_s.rValid = 1'b1;
			next_s.rResp = RESP_OKAY;
			if (araddr == ADDR_CTRL)
			begin
				next_s.rData = '0;
				next_s.rData[CTRL_ITEM_LSB +: 8] = s.itemNumber;
				next_s.rData[CTRL_COLOUR_BIT] = s.colourSupport;
			end
			else if (araddr == ADDR_STATUS)
			begin
				next_s.rData = statusWord;
			end
			else
			begin
				next_s.rData = '0;
				next_s.rResp = RESP_SLVERR;
			end
		end
		next_s.arReady = !next_s.rValid;

		// write-1-to-clear of the error bit; a new error below wins
		if (doWrite && s.awAddr == ADDR_STATUS && s.wStrb[3] && s.wData[ST_ERR_BIT])
		begin
			next_s.error = 1'b0;
		end

		// parser: a label start outranks a byte in the same cycle
		if (labelStart)
		begin
			next_s.literal = 1'b0;
			next_s.pst = P_TEXT;
			next_s.penCol = COL_FIRST;
			next_s.blink = 1'b0;
			next_s.inverse = 1'b0;
			next_s.underline = 1'b0;
			next_s.fg = COLOUR_NONE;
			next_s.bg = COLOUR_NONE;
			next_s.colourCount = '0;
		end
		else if (byteValid)
		begin
			next_s.pst = P_TEXT;
			case (s.pst)
				P_TEXT:
				begin
					asText = 1'b1;
				end
				P_ESC_LIT:
				begin
					// literal escape was drawn; an ampersand still opens attributes
					if (byteData == CH_AMP)
					begin
						next_s.pst = P_AMP;
					end
					else
					begin
						asText = 1'b1;
					end
				end
				P_ESC:
				begin
					// single-letter commands; unknown ones are dropped, neither drawn nor executed
					if (byteData == CH_C)
					begin
						if (s.penCol != COL_LAST)
						begin
							next_s.penCol = s.penCol + 7'h01;
						end
					end
					else if (byteData == CH_G)
					begin
						next_s.penCol = COL_FIRST;
					end
					else if (byteData == CH_K)
					begin
						next_s.clearToEnd = 1'b1;
					end
					else if (byteData == CH_Y && !itemSet)
					begin
						next_s.literal = 1'b1;
					end
					else if (byteData == CH_Z && !itemSet)
					begin
						next_s.literal = 1'b0;
					end
					else if (byteData == CH_AMP)
					begin
						next_s.pst = P_AMP;
					end
				end
				P_AMP:
				begin
					if (byteData == CH_D_LOW)
					begin
						next_s.pst = P_ENH;
					end
					else if (byteData == CH_V_LOW)
					begin
						next_s.pst = P_CSIGN;
						next_s.negative = 1'b0;
						next_s.hasDigit = 1'b0;
						next_s.number = '0;
					end
				end
				P_ENH:
				begin
					// selector low three bits: blink, inverse, underline
					if (itemSet && byteData >= CH_AT && byteData <= CH_G)
					begin
						next_s.blink = byteData[0];
						next_s.inverse = byteData[1];
						next_s.underline = byteData[2];
					end
				end
				P_CSIGN, P_CNUM:
				begin
					if (byteData >= CH_ZERO && byteData <= CH_NINE)
					begin
						acc = {3'h0, s.number} * DEC_BASE + (byteData - CH_ZERO);
						next_s.number = (acc > COLOUR_SAT_W) ? COLOUR_SAT : acc[4:0];
						next_s.hasDigit = 1'b1;
						next_s.pst = P_CNUM;
					end
					else if (byteData == CH_MINUS && s.pst == P_CSIGN)
					begin
						next_s.negative = 1'b1;
						next_s.pst = P_CNUM;
					end
					else if (byteData == CH_S && s.hasDigit)
					begin
						if (!s.colourSupport)
						begin
							next_s.error = 1'b1;
						end
						else if (itemSet && s.colourCount != COLOUR_SEQ_MAX && s.number <= COLOUR_MAX)
						begin
							next_s.colourCount = s.colourCount + 2'h1;
							if (s.number == '0)
							begin
								next_s.fg = COLOUR_NONE;
								next_s.bg = COLOUR_NONE;
							end
							else if (s.negative)
							begin
								next_s.bg = s.number[3:0];
							end
							else
							begin
								next_s.fg = s.number[3:0];
							end
						end
					end
				end
				default:
				begin
					next_s.pst = P_TEXT;
				end
			endcase

			// plain text and control codes
			if (asText)
			begin
				if (byteData == CODE_CR)
				begin
					next_s.penCol = COL_FIRST;
				end
				else if (byteData == CODE_LF)
				begin
					next_s.lineFeed = 1'b1;
				end
				else if (byteData == CODE_ESC && !s.literal)
				begin
					next_s.pst = P_ESC;
				end
				else if (byteData == CODE_BS && !s.literal)
				begin
					if (s.penCol != COL_FIRST)
					begin
						next_s.penCol = s.penCol - 7'h01;
					end
				end
				else if (byteData == CODE_FF && !s.literal)
				begin
					next_s.clearLine = 1'b1;
					next_s.penCol = COL_FIRST;
				end
				else if (byteData < CODE_SPACE && !s.literal)
				begin
					// other control codes are silently executed as no-ops
				end
				else
				begin
					// drawn glyph, including controls in literal mode
					next_s.glyphValid = 1'b1;
					next_s.glyphCode = byteData;
					if (s.penCol != COL_LAST)
					begin
						next_s.penCol = s.penCol + 7'h01;
					end
					if (byteData == CODE_ESC)
					begin
						next_s.pst = P_ESC_LIT;
					end
				end
			end
		end

		// a numbered label is always literal
		if (next_s.itemNumber != RST_ITEM)
		begin
			next_s.literal = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.colourSupport <= RST_COLOUR_SUPPORT;
			s.itemNumber <= RST_ITEM;
			s.pst <= P_TEXT;
		end
		else
		begin
			s <= next_s;
		end
	end

	// outputs straight from the record
	assign awready = s.awReady;
	assign wready = s.wReady;
	assign bvalid = s.bValid;
	assign bresp = s.bResp;
	assign arready = s.arReady;
	assign rvalid = s.rValid;
	assign rdata = s.rData;
	assign rresp = s.rResp;
	assign glyphValid = s.glyphValid;
	assign glyphCode = s.glyphCode;
	assign penCol = s.penCol;
	assign clearLine = s.clearLine;
	assign clearToEnd = s.clearToEnd;
	assign lineFeed = s.lineFeed;
	assign literalMode = s.literal;
	assign blink = s.blink;
	assign inverse = s.inverse;
	assign underline = s.underline;
	assign fgColour = s.fg;
	assign bgColour = s.bg;
	assign colourError = s.error;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	logic byteIn;
	assign byteIn = byteValid && !labelStart;

	sequence s_textByte(logic [7:0] code);
		byteIn && s.pst == P_TEXT && byteData == code;
	endsequence
	sequence s_escByte(logic [7:0] code);
		byteIn && s.pst == P_ESC && byteData == code;
	endsequence

	property p_backspace;
		s_textByte(CODE_BS) and (!s.literal && s.penCol != COL_FIRST) |=> penCol == $past(s.penCol) - 7'h01;
	endproperty
	a_backspace: assert property (p_backspace) else $error("backspace did not step pen left");

	property p_formfeed;
		// a second form feed right behind the first keeps the pulse up
		s_textByte(CODE_FF) and (!s.literal) |=> clearLine && penCol == COL_FIRST
			##1 (!clearLine || $past(byteIn && s.pst == P_TEXT && byteData == CODE_FF));
	endproperty
	a_formfeed: assert property (p_formfeed) else $error("form feed did not blank line");

	property p_cr;
		s_textByte(CODE_CR) |=> penCol == COL_FIRST && !glyphValid;
	endproperty
	a_cr: assert property (p_cr) else $error("carriage return not executed");

	property p_escOpen;
		s_textByte(CODE_ESC) and (!s.literal) |=> s.pst == P_ESC && !glyphValid;
	endproperty
	a_escOpen: assert property (p_escOpen) else $error("escape drawn in normal mode");

	property p_escRight;
		s_escByte(CH_C) and (s.penCol != COL_LAST) |=> penCol == $past(s.penCol) + 7'h01;
	endproperty
	a_escRight: assert property (p_escRight) else $error("escape C did not move pen");

	property p_clearEnd;
		s_escByte(CH_K) |=> clearToEnd ##1 !clearToEnd;
	endproperty
	a_clearEnd: assert property (p_clearEnd) else $error("escape K did not clear");

	property p_enhGate;
		byteIn && s.pst == P_ENH && s.itemNumber == RST_ITEM |=> $stable({blink, inverse, underline});
	endproperty
	a_enhGate: assert property (p_enhGate) else $error("enhancement applied without item number");

	property p_colourLimit;
		s.colourCount == COLOUR_SEQ_MAX && !labelStart |=> $stable({fgColour, bgColour});
	endproperty
	a_colourLimit: assert property (p_colourLimit) else $error("fourth colour sequence honoured");

	property p_monoError;
		byteIn && s.pst == P_CNUM && byteData == CH_S && s.hasDigit && !s.colourSupport
			|=> colourError [*2];
	endproperty
	a_monoError: assert property (p_monoError) else $error("colour on mono variant not flagged");

	property p_literalDraw;
		s_textByte(CODE_BS) and (s.literal) |=> glyphValid && glyphCode == CODE_BS;
	endproperty
	a_literalDraw: assert property (p_literalDraw) else $error("literal mode did not draw control");

	property p_newLabel;
		// a write landing in the same cycle may number the label
		labelStart && s.itemNumber == RST_ITEM && !(s.awHeld && s.wHeld && !s.bValid) |=> !literalMode;
	endproperty
	a_newLabel: assert property (p_newLabel) else $error("new label left literal mode on");

	property p_itemForce;
		s.itemNumber != RST_ITEM |-> literalMode;
	endproperty
	a_itemForce: assert property (p_itemForce) else $error("numbered label not literal");

endmodule

// [label_source.sv]
`timescale 1ns/1ps
// host side of the byte stream: feeds delimited label strings one byte at a time
module label_source
	import label_parser_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	output logic labelStart,
	output logic byteValid,
	output logic [7:0] byteData
);
	int colourSeqs = 0; // colour sequences sent in this label
	bit overLimit = 0; // set by the bench only to push a fourth one through

	// idle stream at time zero
	initial
	begin
		labelStart = 1'b0;
		byteValid = 1'b0;
		byteData = 8'h00;
	end

	////////////////////////////////////////////////////////////
	// a one-cycle pulse opens a fresh label
	task automatic newLabel();
		@(posedge ref_clk);
		labelStart <= 1'b1;
		colourSeqs = 0;
		@(posedge ref_clk);
		labelStart <= 1'b0;
	endtask

	// one byte; the last one of a burst releases the stream
	task automatic sendByte(input logic [7:0] b, input bit last);
		@(posedge ref_clk);
		byteValid <= 1'b1;
		byteData <= b;
		if (last)
		begin
			@(posedge ref_clk);
			byteValid <= 1'b0;
			byteData <= ~b; // released data shows junk, never the old byte
		end
	endtask

	// '~' stands for the escape byte; all bytes go back to back
	task automatic sendStr(input string s);
		logic [7:0] b;
		if (s.len() > 2 && s[1] == CH_AMP && s[2] == CH_V_LOW)
		begin
			if (colourSeqs == 3 && !overLimit)
				return;
			colourSeqs++;
		end
		for (int i = 0; i < s.len(); i++)
		begin
			b = s[i];
			if (b == 8'h7E)
				b = CODE_ESC; // command opens with escape
			sendByte(b, i == s.len() - 1);
		end
	endtask
endmodule

// [label_text_escape_parser_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nMismatch++; \
$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module label_text_escape_parser_test
	import label_parser_pkg::*;
;
	logic ref_clk, rst_b;
	logic [3:0] awaddr, araddr, wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic labelStart, byteValid, glyphValid, clearLine, clearToEnd, lineFeed, literalMode;
	logic blink, inverse, underline, colourError;
	logic [7:0] byteData, glyphCode;
	logic [6:0] penCol;
	logic [3:0] fgColour, bgColour;
	int nMismatch = 0;
	int cmpCount = 0;
	logic [31:0] rd_d; // last read word
	logic [1:0] rsp; // last response

	label_text_escape_parser i_label_text_escape_parser (.ref_clk(ref_clk), .rst_b(rst_b),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .labelStart(labelStart), .byteValid(byteValid),
		.byteData(byteData), .glyphValid(glyphValid), .glyphCode(glyphCode), .penCol(penCol),
		.clearLine(clearLine), .clearToEnd(clearToEnd), .lineFeed(lineFeed),
		.literalMode(literalMode), .blink(blink), .inverse(inverse), .underline(underline),
		.fgColour(fgColour), .bgColour(bgColour), .colourError(colourError));
	label_source i_label_source (.ref_clk(ref_clk), .rst_b(rst_b), .labelStart(labelStart),
		.byteValid(byteValid), .byteData(byteData));

	// 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////
	// bus master: address and data offered together, each dropped once taken
	// loop ends on a local flag: the ready strobes only change after this time step
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		bit done;
		n = 0;
		done = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 50)
		begin
			@(posedge ref_clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				rsp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			nMismatch++;
	endtask

	// read one word; no fixed latency is assumed
	task automatic rd(input logic [3:0] a);
		int n;
		bit done;
		n = 0;
		done = 1'b0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 50)
		begin
			@(posedge ref_clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				rd_d = rdata;
				rsp = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			nMismatch++;
	endtask

	// send a string and let the answering edge land
	task automatic tx(input string s);
		i_label_source.sendStr(s);
		#1;
	endtask

	task automatic tx1(input logic [7:0] b);
		i_label_source.sendByte(b, 1'b1);
		#1;
	endtask

	task automatic lbl();
		i_label_source.newLabel();
		#1;
	endtask

	////////////////////////////////////////////////////////////
	// reset values and an unmapped address
	task automatic tReset();
		rd(ADDR_CTRL);
		`CHK(rd_d, 32'h00000100);
		rd(ADDR_STATUS);
		`CHK(rd_d, 32'h00000000);
		wr(4'h8, 32'hFFFFFFFF, 4'hF);
		`CHK(rsp, RESP_SLVERR);
		rd(4'h8);
		`CHK(rsp, RESP_SLVERR);
	endtask

	// pen movement and clears in an unnumbered label
	task automatic tPen();
		lbl();
		tx("AB");
		`CHK(penCol, 7'h02);
		tx1(CODE_BS);
		`CHK(penCol, 7'h01);
		`CHK(glyphValid, 1'b0);
		tx("~C");
		`CHK(penCol, 7'h02);
		tx("~G");
		`CHK(penCol, 7'h00);
		tx("AB");
		tx1(CODE_CR);
		`CHK(penCol, 7'h00);
		tx("AB");
		tx1(CODE_FF);
		`CHK(clearLine, 1'b1);
		`CHK(penCol, 7'h00);
		tx("AB~K");
		`CHK(clearToEnd, 1'b1);
		`CHK(penCol, 7'h02);
		tx("~Q");
		`CHK(penCol, 7'h02);
		`CHK(glyphValid, 1'b0);
	endtask

	// literal mode shows controls except line breaks
	task automatic tLiteral();
		tx("~Y");
		`CHK(literalMode, 1'b1);
		tx1(CODE_BS);
		`CHK(glyphValid, 1'b1);
		`CHK(glyphCode, CODE_BS);
		tx1(CODE_CR);
		`CHK(penCol, 7'h00);
		`CHK(glyphValid, 1'b0);
		tx1(CODE_LF);
		`CHK(lineFeed, 1'b1);
		lbl();
		`CHK(literalMode, 1'b0);
	endtask

	// numbered label: forced literal, every enhancement selector
	task automatic tEnhance();
		logic [7:0] sel;
		wr(ADDR_CTRL, 32'h00000001, 4'h1);
		lbl();
		`CHK(literalMode, 1'b1);
		tx("~Z");
		`CHK(literalMode, 1'b1);
		for (int i = 1; i <= 8; i++)
		begin
			sel = CH_AT + 8'(i % 8);
			tx("~&d");
			tx1(sel);
			`CHK({underline, inverse, blink}, sel[2:0]);
		end
		tx("~&dG~&dX");
		`CHK({underline, inverse, blink}, 3'h7);
	endtask

	// colour overrides and the three-per-label limit
	task automatic tColour();
		lbl();
		tx("~&v12S");
		`CHK(fgColour, 4'hC);
		tx("~&v-3S");
		`CHK(bgColour, 4'h3);
		tx("~&v0S");
		`CHK({fgColour, bgColour}, 8'h00);
		i_label_source.overLimit = 1;
		tx("~&v5S");
		i_label_source.overLimit = 0;
		`CHK(fgColour, 4'h0);
		rd(ADDR_STATUS);
		`CHK(rd_d[21:20], 2'h3);
	endtask

	// unnumbered label ignores enhancements and colours
	task automatic tUnnumbered();
		wr(ADDR_CTRL, 32'h00000000, 4'h1);
		lbl();
		tx("~&dA");
		`CHK(blink, 1'b0);
		tx("~&v5S");
		`CHK(fgColour, 4'h0);
	endtask

	// colourless variant flags the sequence; software clears the flag
	task automatic tMono();
		wr(ADDR_CTRL, 32'h00000000, 4'h2);
		tx("~&v5S");
		`CHK(colourError, 1'b1);
		rd(ADDR_STATUS);
		`CHK(rd_d[24], 1'b1);
		wr(ADDR_STATUS, 32'h01000000, 4'h8);
		#1;
		`CHK(colourError, 1'b0);
	endtask

	////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic close_out();
		if (nMismatch == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// main sequence
	initial
	begin
		rst_b = 1'b0;
		{awaddr, araddr, wstrb, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		tReset();
		tPen();
		tLiteral();
		tEnhance();
		tColour();
		tUnnumbered();
		tMono();
		close_out();
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		#200000;
		nMismatch++;
		close_out();
	end
endmodule
